// ---- verilog/sao_regs.svh ----
`ifndef SAO_REGS_SVH
`define SAO_REGS_SVH
// Sample format and frame layout
`define SAO_SAMPLE_W     24
`define SAO_SLOTS        8
`define SAO_LINKS        4
`define SAO_FIFO_DEPTH   32
// MSB index of a word, last slot index of a frame
`define SAO_MSB_IDX      5'h17
`define SAO_SLOT_LAST    3'h7
`endif

// ---- verilog/sao_pkg.sv ----
package sao_pkg;
	// One audio sample, sign plus 23 fractional bits
	typedef logic signed [23:0] sao_sample_type;
	// Four serial links grouped together
	typedef struct packed {
		logic [3:0] sdata;
		logic       wsel;
		logic       bclk;
	} sao_link_type;
	// Frame gathering states
	typedef enum logic [1:0] {
		SAO_GATHER = 2'b00,
		SAO_WAIT   = 2'b01,
		SAO_SEND   = 2'b11
	} sao_state_type;
endpackage

// ---- verilog/sao_out.sv ----
`timescale 1ns/1ps
`include "sao_regs.svh"

// Word FIFO with valid/ready on both sides
module sao_fifo #(
	parameter int WIDTH = `SAO_SAMPLE_W,
	parameter int DEPTH = `SAO_FIFO_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	// Wrap-bit pointers only work for power-of-two depths
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];   // Storage
	logic [AW:0]      wp_r, wp_nxt;  // Write pointer with wrap bit
	logic [AW:0]      rp_r, rp_nxt;  // Read pointer with wrap bit
	logic             push, pop;
	// Full when pointers differ only in the wrap bit
	assign in_ready_o  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid_o = (wp_r != rp_r);
	assign out_data_o  = mem[rp_r[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	// Pointer next values
	always_comb begin
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
	end
	// Pointer registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end
	// Storage write, no reset needed
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_r[AW-1:0]] <= in_data_i;
		end
	end
endmodule // sao_fifo

module sao_out
	import sao_pkg::*;
#(
	parameter int DEPTH = `SAO_FIFO_DEPTH
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic [`SAO_SAMPLE_W-1:0] snk_data_i,
	input  wire logic                  snk_valid_i,
	output logic                       snk_ready_o,
	input  wire logic                  bclk_i,
	output logic                       bclk_o,
	output logic                       wsel_o,
	output logic [`SAO_LINKS-1:0]      sdata_o,
	output logic                       irq_o
);
	localparam int CW = $clog2(DEPTH) + 1; // Occupancy count width
	// One frame must fit while the previous one drains
	if (DEPTH < 2 * `SAO_SLOTS) begin : g_small_depth
		$error("DEPTH too small for one frame");
	end
	sao_sample_type   fifo_data;               // FIFO head
	logic             fifo_valid, fifo_ready;  // FIFO drain side
	logic             fifo_in_ready;           // FIFO fill side
	logic [2:0]       bs_r;                    // Bit clock synchroniser
	logic             bprev_r;                 // Last agreed bit clock level
	logic             fall, rise;              // Bit clock edges
	sao_state_type    st_r, st_nxt;            // Frame state
	logic [2:0]       slot_r, slot_nxt;        // Gathered slot index
	sao_sample_type   frame_r   [`SAO_SLOTS];  // Gathered frame
	sao_sample_type   frame_nxt [`SAO_SLOTS];
	sao_sample_type   shl_r     [`SAO_LINKS];  // Per-link shift words
	sao_sample_type   shl_nxt   [`SAO_LINKS];
	logic [4:0]       bit_r, bit_nxt;          // Bit index in word
	logic             ws_r, ws_nxt;            // Word select
	logic             hr_r, hr_nxt;            // Right half loaded
	sao_link_type     lk_r, lk_nxt;            // Registered pins
	logic             rdy_r, rdy_nxt;          // Registered sink ready
	logic [CW-1:0]    cnt_r, cnt_nxt;          // Mirror of FIFO occupancy
	logic             take, drain;             // Sample in, sample out

	// Sink handshake pulls from the upstream source only when room exists
	assign snk_ready_o = rdy_r;
	sao_fifo #(.WIDTH(`SAO_SAMPLE_W), .DEPTH(DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.rst_b_i     (rst_b_i),
		.in_data_i   (snk_data_i),
		.in_valid_i  (snk_valid_i && rdy_r),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_ready)
	);
	// Drain only while gathering; frames wait for the DAC timing
	assign fifo_ready = (st_r == SAO_GATHER);
	assign take       = snk_valid_i && rdy_r;
	assign drain      = fifo_valid && fifo_ready;
	// Bit clock edges once stages two and three agree
	assign fall = bprev_r && !bs_r[1] && !bs_r[2];
	assign rise = !bprev_r && bs_r[1] && bs_r[2];

	// Frame gathering and serialising next state
	always_comb begin
		st_nxt    = st_r;
		slot_nxt  = slot_r;
		frame_nxt = frame_r;
		shl_nxt   = shl_r;
		bit_nxt   = bit_r;
		ws_nxt    = ws_r;
		hr_nxt    = hr_r;
		lk_nxt    = lk_r;
		cnt_nxt   = cnt_r + CW'(take) - CW'(drain);
		// Ready from next cycle's occupancy, so an accepted sample is never lost
		rdy_nxt   = (cnt_nxt < CW'(DEPTH));
		unique case (st_r)
			SAO_GATHER: begin
				if (fifo_valid) begin
					frame_nxt[slot_r] = fifo_data;
					slot_nxt = slot_r + 3'h1;
					if (slot_r == `SAO_SLOT_LAST) begin
						st_nxt = SAO_WAIT;
					end
				end
			end
			SAO_WAIT: begin
				// Start at a left slot boundary only
				if (fall && ws_r && bit_r == 5'h0) begin
					st_nxt = SAO_SEND;
				end
			end
			SAO_SEND: begin
				// Frame store is free once the right words are loaded,
				// so the next frame gathers during the right slot
				if (hr_r) begin
					st_nxt = SAO_GATHER;
				end
			end
			default: st_nxt = SAO_GATHER;
		endcase
		// Serialiser free-runs on bit clock falls
		if (fall) begin
			if (bit_r == 5'h0) begin
				ws_nxt  = !ws_r;
				bit_nxt = `SAO_MSB_IDX + 5'h1;
				hr_nxt  = 1'b0;
				for (int k = 0; k < `SAO_LINKS; k++) begin
					// Left slot from even index, right from odd
					shl_nxt[k] = (st_r == SAO_WAIT && ws_r) ? frame_r[2*k] :
						(st_r == SAO_SEND && !ws_r) ? frame_r[2*k+1] : '0;
				end
				hr_nxt = (st_r == SAO_SEND && !ws_r);
			end else begin
				bit_nxt = bit_r - 5'h1;
			end
			// MSB emerges one bit clock after the select change
			for (int k = 0; k < `SAO_LINKS; k++) begin
				lk_nxt.sdata[k] = (bit_r <= `SAO_MSB_IDX) ? shl_r[k][bit_r] : 1'b0;
			end
			lk_nxt.wsel = ws_r;
		end
		lk_nxt.bclk = bs_r[2];
	end

	// State registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bs_r    <= '0;
			bprev_r <= 1'b0;
			st_r    <= SAO_GATHER;
			slot_r  <= '0;
			frame_r <= '{default: '0};
			shl_r   <= '{default: '0};
			bit_r   <= '0;
			ws_r    <= 1'b1;
			hr_r    <= 1'b0;
			lk_r    <= '0;
			rdy_r   <= 1'b0;
			cnt_r   <= '0;
			irq_o   <= 1'b0;
		end else begin
			bs_r    <= {bs_r[1:0], bclk_i};
			bprev_r <= (bs_r[1] == bs_r[2]) ? bs_r[2] : bprev_r;
			st_r    <= st_nxt;
			slot_r  <= slot_nxt;
			frame_r <= frame_nxt;
			shl_r   <= shl_nxt;
			bit_r   <= bit_nxt;
			ws_r    <= ws_nxt;
			hr_r    <= hr_nxt;
			lk_r    <= lk_nxt;
			rdy_r   <= rdy_nxt;
			cnt_r   <= cnt_nxt;
			irq_o   <= 1'b0;
		end
	end
	assign bclk_o  = lk_r.bclk;
	assign wsel_o  = lk_r.wsel;
	assign sdata_o = lk_r.sdata;

	// Checks
	frame_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_r == SAO_GATHER && st_nxt == SAO_WAIT) |-> slot_r == `SAO_SLOT_LAST)
		else $error("frame closed at wrong slot");
	no_pull_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		st_r != SAO_GATHER |-> !fifo_ready)
		else $error("drain outside gather");
	irq_low_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!irq_o)
		else $error("irq raised");
	ws_toggle_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(fall && bit_r == 5'h0) |=> ws_r != $past(ws_r))
		else $error("word select did not toggle");
	send_start_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st_r == SAO_WAIT && st_nxt == SAO_SEND) |=> !ws_r)
		else $error("frame did not start on left");
	ready_fifo_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		snk_ready_o |-> fifo_in_ready)
		else $error("ready without room");
	frame_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		st_r == SAO_SEND ##1 st_r == SAO_GATHER);
	full_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) !fifo_in_ready);
	pull_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		snk_valid_i && snk_ready_o);
endmodule // sao_out

// ---- dv/sao_dac_model.sv ----
`timescale 1ns/1ps
// Four stereo DACs and the PLL bit clock that paces them
module sao_dac_model (
	input  wire logic         rst_b_i,
	input  wire logic         sck_i,
	input  wire logic         ws_i,
	input  wire logic [3:0]   sd_i,
	output logic              bclk_o,
	output logic [191:0]      frame_o,
	output logic [15:0]       frames_o
);
	logic        ws_r;     // Select at last edge
	int          bit_r;    // Bit clocks since select edge
	logic [23:0] sh_r [4]; // Shift register per link
	// Free-running PLL clock, phase unrelated to clk_i
	initial begin
		bclk_o = 1'b0;
		#137;
		forever #400 bclk_o = ~bclk_o;
	end
	// Sample on rising bit clock; MSB one clock after select edge
	always @(posedge sck_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ws_r = 1'b0;
			bit_r = 99;
			frame_o = '0;
			frames_o = 16'h0;
		end else begin
			bit_r = (ws_i != ws_r) ? 0 : bit_r + 1;
			ws_r = ws_i;
			for (int k = 0; k < 4; k++) begin
				if (bit_r >= 1 && bit_r <= 24) sh_r[k] = {sh_r[k][22:0], sd_i[k]};
				if (bit_r == 24) frame_o[(7-2*k-ws_i)*24 +: 24] = sh_r[k];
			end
			// Frame ends with the right word
			if (bit_r == 24 && ws_i) frames_o = frames_o + 16'h1;
		end
	end
endmodule // sao_dac_model

// ---- dv/sao_out_tb.sv ----
`timescale 1ns/1ps
module sao_out_tb
	import sao_pkg::*;
;
	logic           clk_i, rst_b_i, snk_valid_i, snk_ready_o; // Clock, reset, sink
	logic           pll_clk, bclk_o, wsel_o, irq_o;            // Link side
	sao_sample_type snk_data_i;                                // Offered sample
	logic [3:0]     sdata_o;                                   // Link data
	logic [191:0]   frame;                                     // Last frame seen
	logic [15:0]    frames;                                    // Frames seen
	logic [191:0]   got_q [$];                                 // Non-idle frames
	int             bad_count, compares;
	logic           saw_full, irq_any;
	// Rows: sub pair, centre pair, front, rear; boundary values
	logic [191:0]   rows [2] = '{
		{24'h7fffff, 24'h7fffff, 24'h800000, 24'h800000,
		 24'h000001, 24'hfffffe, 24'h123456, 24'hedcba9},
		{24'h800001, 24'h800001, 24'h7ffffe, 24'h7ffffe,
		 24'h555555, 24'haaaaaa, 24'h0f0f0f, 24'hf0f0f0}};

	sao_out uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .snk_data_i(snk_data_i),
		.snk_valid_i(snk_valid_i), .snk_ready_o(snk_ready_o), .bclk_i(pll_clk),
		.bclk_o(bclk_o), .wsel_o(wsel_o), .sdata_o(sdata_o), .irq_o(irq_o));
	sao_dac_model dac (.rst_b_i(rst_b_i), .sck_i(bclk_o), .ws_i(wsel_o), .sd_i(sdata_o),
		.bclk_o(pll_clk), .frame_o(frame), .frames_o(frames));

	task automatic check(input logic [191:0] got, input logic [191:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Hold sample until ready seen high at an edge
	task automatic push(input sao_sample_type d);
		snk_data_i <= d;
		snk_valid_i <= 1'b1;
		do begin
			@(negedge clk_i);
			if (snk_ready_o !== 1'b1) saw_full = 1'b1;
		end while (snk_ready_o !== 1'b1);
		@(posedge clk_i);
	endtask
	// Whole frame in sink order
	task automatic send(input logic [191:0] f);
		for (int i = 0; i < 8; i++) push(f[(7-i)*24 +: 24]);
	endtask
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Idle frames carry zeros and are skipped
	always @(frames) if (rst_b_i && frame != '0) got_q.push_back(frame);
	always @(posedge clk_i) if (rst_b_i && irq_o !== 1'b0) irq_any = 1'b1;
	// Watchdog well past nine paced frames
	initial begin
		#2000000;
		bad_count++;
		summarize();
	end
	initial begin
		logic [191:0] b;
		rst_b_i = 1'b1;
		snk_valid_i = 1'b0;
		snk_data_i = '0;
		bad_count = 0;
		compares = 0;
		saw_full = 1'b0;
		irq_any = 1'b0;
		// Clean falling edge once every process is waiting on it
		#1;
		rst_b_i = 1'b0;
		repeat (4) @(posedge clk_i);
		check({sdata_o, wsel_o, bclk_o, snk_ready_o, irq_o}, '0);
		$display("Reset test done");
		repeat (4) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		// Row loop: link k gets samples 2k left, 2k+1 right
		foreach (rows[r]) send(rows[r]);
		snk_valid_i <= 1'b0;
		wait (got_q.size() >= 2);
		foreach (rows[r]) check(got_q[r], rows[r]);
		$display("Row tests done");
		// Burst past FIFO depth: ready must drop, nothing lost
		saw_full = 1'b0;
		@(posedge clk_i);
		for (int f = 0; f < 6; f++) begin
			for (int i = 0; i < 8; i++) b[(7-i)*24 +: 24] = {8'(f + 1), 16'(i + 16'h0a00)};
			send(b);
		end
		snk_valid_i <= 1'b0;
		check(191'(saw_full), 191'(1'b1));
		wait (got_q.size() >= 8);
		for (int f = 0; f < 6; f++) begin
			for (int i = 0; i < 8; i++) b[(7-i)*24 +: 24] = {8'(f + 1), 16'(i + 16'h0a00)};
			check(got_q[f+2], b);
		end
		check(191'(irq_any), '0);
		$display("Burst test done");
		// Mid-run reset: pins clear at once, then a fresh frame still passes
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check({sdata_o, wsel_o, bclk_o, snk_ready_o, irq_o}, '0);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		send(rows[0]);
		snk_valid_i <= 1'b0;
		wait (got_q.size() >= 9);
		check(got_q[8], rows[0]);
		$display("Mid-run reset test done");
		summarize();
	end
endmodule // sao_out_tb
